/* pkg/mac_pkg.sv */
package mac_pkg;

    // ------------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------------
    localparam int          BUS_ADDR_W   = 6;
    localparam int          BUS_DATA_W   = 32;
    localparam logic [5:0]  OFF_OPA_LO   = 6'h00;
    localparam logic [5:0]  OFF_OPA_HI   = 6'h04;
    localparam logic [5:0]  OFF_OPB_LO   = 6'h08;
    localparam logic [5:0]  OFF_OPB_HI   = 6'h0C;
    localparam logic [5:0]  OFF_RESULT0  = 6'h10;
    localparam logic [5:0]  OFF_RESULT1  = 6'h14;
    localparam logic [5:0]  OFF_RESULT2  = 6'h18;
    localparam logic [5:0]  OFF_RESULT3  = 6'h1C;
    localparam logic [5:0]  OFF_CONTROL  = 6'h20;
    localparam logic [5:0]  OFF_STATUS   = 6'h24;
    localparam logic [5:0]  OFF_IRQ_STAT = 6'h28;
    localparam logic [5:0]  OFF_IRQ_MASK = 6'h2C;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int          STAT_BUSY_BIT = 0;
    localparam int          STAT_OVF_BIT  = 1;
    localparam int          STAT_SIGN_BIT = 2;
    localparam int          IRQ_N         = 2;
    localparam int          IRQ_DONE_BIT  = 0;
    localparam int          IRQ_OVF_BIT   = 1;
    localparam logic [15:0] WORD_RESET    = 16'h0000;
    localparam logic [1:0]  IRQ_RESET     = 2'h0;

    // ------------------------------------------------------------------
    // Result latencies in clocks, counted from the start edge
    // ------------------------------------------------------------------
    localparam logic [2:0]  LAT_WORD0 = 3'h2;
    localparam logic [2:0]  LAT_WORD1 = 3'h4;
    localparam logic [2:0]  LAT_UPPER = 3'h5;

    // Control register, bit 0 upward: accumulate, signed, fixed point.
    typedef struct packed {
        logic fixed_point;
        logic signed_mode;
        logic accumulate;
    } mac_mode_s;

    localparam mac_mode_s MODE_RESET = 3'h0;

endpackage

/* pkg/mac_core_if.sv */
`timescale 1ns/1ps
interface mac_core_if;
    import mac_pkg::*;

    logic            start;
    mac_mode_s       mode;
    logic [31:0]     op_a;
    logic [31:0]     op_b;
    logic [63:0]     acc_in;
    logic [63:0]     sum;
    logic            overflow;
    logic            sign;
    logic            wr_word0;
    logic            wr_word1;
    logic            wr_upper;
    logic            busy;
    logic [IRQ_N-1:0] irq_event;
    logic [IRQ_N-1:0] irq_clear;
    logic            mask_we;
    logic [IRQ_N-1:0] mask_wdata;
    logic [IRQ_N-1:0] irq_status;
    logic [IRQ_N-1:0] irq_mask;
    logic            irq_line;

    modport top  (output start, mode, op_a, op_b, acc_in, irq_event, irq_clear, mask_we,
                  mask_wdata,
                  input  sum, overflow, sign, wr_word0, wr_word1, wr_upper, busy,
                  irq_status, irq_mask, irq_line);
    modport pipe (input  start, mode, op_a, op_b, acc_in,
                  output sum, overflow, sign, wr_word0, wr_word1, wr_upper, busy);
    modport irq  (input  irq_event, irq_clear, mask_we, mask_wdata,
                  output irq_status, irq_mask, irq_line);
endinterface

/* verilog/mac_pipe.sv */
`timescale 1ns/1ps
module mac_pipe
    import mac_pkg::*;
(
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic reset_i,
    // Core link
    mac_core_if.pipe  core
);

    logic [2:0]         count;
    logic signed [63:0] prod_s;
    logic [63:0]        prod_u;
    logic [63:0]        prod;
    logic [64:0]        next_sum;
    logic               next_ovf;
    logic               next_sign;

    // ------------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------------
    // One datapath serves all four operations, so latency cannot differ.
    assign prod_s = $signed(core.op_a) * $signed(core.op_b);
    assign prod_u = {32'h0000_0000, core.op_a} * {32'h0000_0000, core.op_b};

    always_comb begin
        prod = core.mode.signed_mode ? prod_s : prod_u;
        if (core.mode.fixed_point) begin
            prod = {prod[62:0], 1'b0};
        end
        next_ovf  = 1'b0;
        next_sign = 1'b0;
        if (core.mode.accumulate) begin
            next_sum = {1'b0, core.acc_in} + {1'b0, prod};
            if (core.mode.signed_mode) begin
                next_ovf  = (core.acc_in[63] == prod[63]) && (next_sum[63] != prod[63]);
                next_sign = next_sum[63];
            end else begin
                next_ovf  = next_sum[64];
            end
        end else begin
            next_sum = {1'b0, prod};
            next_sign = core.mode.signed_mode & prod[63];
        end
    end

    // The accumulator is read at count 1, before word 0 is overwritten.
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            core.sum      <= 64'h0;
            core.overflow <= 1'b0;
            core.sign     <= 1'b0;
        end else if (count == 3'h1) begin
            core.sum      <= next_sum[63:0];
            core.overflow <= next_ovf;
            core.sign     <= next_sign;
        end
    end

    // ------------------------------------------------------------------
    // Latency counter
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            count <= 3'h0;
        end else if (core.start) begin
            count <= 3'h1;
        end else if (count == LAT_UPPER) begin
            count <= 3'h0;
        end else if (count != 3'h0) begin
            count <= count + 3'h1;
        end
    end

    assign core.wr_word0 = (count == LAT_WORD0);
    assign core.wr_word1 = (count == LAT_WORD1);
    assign core.wr_upper = (count == LAT_UPPER);
    assign core.busy     = (count != 3'h0);

endmodule

/* verilog/mac_irq.sv */
`timescale 1ns/1ps
module mac_irq
    import mac_pkg::*;
(
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic reset_i,
    // Core link
    mac_core_if.irq   core
);

    // A new event in the clearing cycle survives, set wins over clear.
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            core.irq_status <= IRQ_RESET;
        end else begin
            core.irq_status <= (core.irq_status & ~core.irq_clear) | core.irq_event;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            core.irq_mask <= IRQ_RESET;
        end else if (core.mask_we) begin
            core.irq_mask <= core.mask_wdata;
        end
    end

    assign core.irq_line = |(core.irq_status & core.irq_mask);

endmodule

/* verilog/mac_top.sv */
// Summary of operation
// - Writing operand B upper word starts calculation.
// - Result words valid after 2, 4, 5 clocks.
// - Same latency for signed, unsigned, multiply, accumulate.
// - Fixed-point mode does not change latency.
// - Multiply places 64-bit product across four words.
// - Accumulate adds product to held 64-bit result.
`timescale 1ns/1ps
module mac_top
    import mac_pkg::*;
#(
    parameter int ADDR_W = BUS_ADDR_W
) (
    // Clock and reset
    input  wire logic              clock_i,
    input  wire logic              reset_i,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output      logic [31:0]       avs_readdata_o,
    output      logic              avs_waitrequest_o,
    // Interrupt
    output      logic              irq_o
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (ADDR_W < BUS_ADDR_W) begin : g_addr_check
        $error("mac_top: ADDR_W too small for the register map.");
    end

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    mac_core_if core ();

    logic        ack;
    logic        access;
    logic        wr_en;
    logic        rd_take;
    logic [31:0] read_mux;
    logic [15:0] op_a_lo;
    logic [15:0] op_a_hi;
    logic [15:0] op_b_lo;
    logic [15:0] op_b_hi;
    logic [15:0] result_word_0;
    logic [15:0] result_word_1;
    logic [15:0] result_word_2;
    logic [15:0] result_word_3;
    mac_mode_s   mode;
    logic        accumulate_overflow_flag;
    logic        accumulate_sign_flag;
    logic        calc_busy_bit;

    function automatic logic hit(input logic [5:0] off);
        hit = (avs_address_i == ADDR_W'(off));
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old);
        merge16 = {avs_byteenable_i[1] ? avs_writedata_i[15:8] : old[15:8],
                   avs_byteenable_i[0] ? avs_writedata_i[7:0]  : old[7:0]};
    endfunction

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    // Every access costs one wait state so read data can come from a flop.
    assign access            = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = access & ~ack;
    assign wr_en             = avs_write_i & ack;
    assign rd_take           = avs_read_i & ~ack;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            ack <= 1'b0;
        end else begin
            ack <= access & ~ack;
        end
    end

    always_comb begin
        read_mux = 32'h0000_0000;
        case (avs_address_i)
            ADDR_W'(OFF_OPA_LO):   read_mux[15:0] = op_a_lo;
            ADDR_W'(OFF_OPA_HI):   read_mux[15:0] = op_a_hi;
            ADDR_W'(OFF_OPB_LO):   read_mux[15:0] = op_b_lo;
            ADDR_W'(OFF_OPB_HI):   read_mux[15:0] = op_b_hi;
            ADDR_W'(OFF_RESULT0):  read_mux[15:0] = result_word_0;
            ADDR_W'(OFF_RESULT1):  read_mux[15:0] = result_word_1;
            ADDR_W'(OFF_RESULT2):  read_mux[15:0] = result_word_2;
            ADDR_W'(OFF_RESULT3):  read_mux[15:0] = result_word_3;
            ADDR_W'(OFF_CONTROL):  read_mux[2:0]  = mode;
            ADDR_W'(OFF_STATUS): begin
                read_mux[STAT_BUSY_BIT] = calc_busy_bit;
                read_mux[STAT_OVF_BIT]  = accumulate_overflow_flag;
                read_mux[STAT_SIGN_BIT] = accumulate_sign_flag;
            end
            ADDR_W'(OFF_IRQ_STAT): read_mux[IRQ_N-1:0] = core.irq_status;
            ADDR_W'(OFF_IRQ_MASK): read_mux[IRQ_N-1:0] = core.irq_mask;
            default:               read_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (rd_take) begin
            avs_readdata_o <= read_mux;
        end
    end

    // ------------------------------------------------------------------
    // Operand registers
    // ------------------------------------------------------------------
    // Writes while busy are not blocked; the processor is trusted to hold
    // off, and the result is simply undefined if it does not.
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            op_a_lo <= WORD_RESET;
            op_a_hi <= WORD_RESET;
        end else if (wr_en && hit(OFF_OPA_LO)) begin
            op_a_lo <= merge16(op_a_lo);
        end else if (wr_en && hit(OFF_OPA_HI)) begin
            op_a_hi <= merge16(op_a_hi);
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            op_b_lo <= WORD_RESET;
            op_b_hi <= WORD_RESET;
        end else if (wr_en && hit(OFF_OPB_LO)) begin
            op_b_lo <= merge16(op_b_lo);
        end else if (wr_en && hit(OFF_OPB_HI)) begin
            op_b_hi <= merge16(op_b_hi);
        end
    end

    // The start writes only the upper half of B, so every other setting
    // must already be in place when it lands.
    assign core.start = wr_en && hit(OFF_OPB_HI);

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            mode <= MODE_RESET;
        end else if (wr_en && hit(OFF_CONTROL) && avs_byteenable_i[0]) begin
            mode <= avs_writedata_i[2:0];
        end
    end

    assign core.mode   = mode;
    assign core.op_a   = {op_a_hi, op_a_lo};
    assign core.op_b   = {op_b_hi, op_b_lo};
    assign core.acc_in = {result_word_3, result_word_2, result_word_1, result_word_0};

    // ------------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------------
    // The calculation has priority over a bus write in the same cycle.
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            result_word_0 <= WORD_RESET;
        end else if (core.wr_word0) begin
            result_word_0 <= core.sum[15:0];
        end else if (wr_en && hit(OFF_RESULT0)) begin
            result_word_0 <= merge16(result_word_0);
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            result_word_1 <= WORD_RESET;
        end else if (core.wr_word1) begin
            result_word_1 <= core.sum[31:16];
        end else if (wr_en && hit(OFF_RESULT1)) begin
            result_word_1 <= merge16(result_word_1);
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            result_word_2 <= WORD_RESET;
            result_word_3 <= WORD_RESET;
        end else if (core.wr_upper) begin
            result_word_2 <= core.sum[47:32];
            result_word_3 <= core.sum[63:48];
        end else if (wr_en && hit(OFF_RESULT2)) begin
            result_word_2 <= merge16(result_word_2);
        end else if (wr_en && hit(OFF_RESULT3)) begin
            result_word_3 <= merge16(result_word_3);
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            accumulate_overflow_flag <= 1'b0;
            accumulate_sign_flag     <= 1'b0;
        end else if (core.wr_upper) begin
            accumulate_overflow_flag <= core.overflow;
            accumulate_sign_flag     <= core.sign;
        end
    end

    assign calc_busy_bit = core.busy;

    // ------------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------------
    assign core.irq_event[IRQ_DONE_BIT] = core.wr_upper;
    assign core.irq_event[IRQ_OVF_BIT]  = core.wr_upper & core.overflow;
    assign core.irq_clear  = (wr_en && hit(OFF_IRQ_STAT) && avs_byteenable_i[0]) ?
                             avs_writedata_i[IRQ_N-1:0] : IRQ_RESET;
    assign core.mask_we    = wr_en && hit(OFF_IRQ_MASK) && avs_byteenable_i[0];
    assign core.mask_wdata = avs_writedata_i[IRQ_N-1:0];
    assign irq_o           = core.irq_line;

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    mac_pipe i_mac_pipe (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .core    (core)
    );

    mac_irq i_mac_irq (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .core    (core)
    );

endmodule

/* tb/mac_cpu_model.sv */
`timescale 1ns/1ps
module mac_cpu_model
    import mac_pkg::*;
(
    // Clock
    input  wire logic        clock_i,
    // Slave answer
    input  wire logic        waitrequest_i,
    input  wire logic [31:0] readdata_i,
    // Master request
    output      logic [5:0]  address_o,
    output      logic        read_o,
    output      logic        write_o,
    output      logic [31:0] writedata_o,
    output      logic [3:0]  byteenable_o
);
    initial begin
        address_o = 6'h3F;
        read_o = 1'b0;
        write_o = 1'b0;
        writedata_o = 32'h0;
        byteenable_o = 4'h0;
    end

    // One access at a time, so nothing is rewritten behind a pending one.
    // Released address and write data lines show inverted values so stale data cannot pass.
    task automatic access(input logic wr, input logic [5:0] adr, input logic [31:0] wd,
                          input logic [3:0] ben, output logic [31:0] rdv, output bit ok);
        ok = 1'b0;
        rdv = 32'h0;
        @(posedge clock_i);
        address_o <= adr;
        read_o <= !wr;
        write_o <= wr;
        writedata_o <= wd;
        byteenable_o <= ben;
        // Waitrequest and read data are taken at the rising edge itself, before the
        // slave's flops move, so both show what the slave drove into that edge.
        for (int n = 0; n < 16 && !ok; n++) begin
            @(posedge clock_i);
            if (waitrequest_i === 1'b0) begin
                ok = 1'b1;
                rdv = readdata_i;
            end
        end
        read_o <= 1'b0;
        write_o <= 1'b0;
        address_o <= ~adr;
        writedata_o <= ~wd;
    endtask
endmodule

/* tb/mac_top_assertions.sv */
`timescale 1ns/1ps
module mac_top_assertions
    import mac_pkg::*;
#(
    parameter int ADDR_W = BUS_ADDR_W
) (
    // Watched ports
    input wire logic              clock_i,
    input wire logic              reset_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic              avs_read_i,
    input wire logic              avs_write_i,
    input wire logic [31:0]       avs_writedata_i,
    input wire logic [3:0]        avs_byteenable_i,
    input wire logic [31:0]       avs_readdata_o,
    input wire logic              avs_waitrequest_o,
    input wire logic              irq_o
);
    logic       done_w;
    logic       rd_stat;
    logic       mask_wr;
    logic       stat_wr;
    logic [2:0] since;
    assign done_w = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
    assign rd_stat = done_w & avs_read_i & (avs_address_i == OFF_STATUS);
    assign mask_wr = done_w & avs_write_i & (avs_address_i == OFF_IRQ_MASK);
    assign stat_wr = done_w & avs_write_i & (avs_address_i == OFF_IRQ_STAT);

    // Edges since the last start; parks at 7 so idle never looks busy.
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            since <= 3'h7;
        end else if (done_w && avs_write_i && avs_address_i == OFF_OPB_HI) begin
            since <= 3'h0;
        end else if (since != 3'h7) begin
            since <= since + 3'h1;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    one_wait_a: assert property ($rose(avs_read_i | avs_write_i)
        |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("request not answered after one wait state");
    idle_nowait_a: assert property (!(avs_read_i | avs_write_i) |-> !avs_waitrequest_o)
        else $error("waitrequest without request");
    busy_set_a: assert property (
        rd_stat && $past(since) < 3'h5 |-> avs_readdata_o[STAT_BUSY_BIT])
        else $error("busy not shown during calculation");
    busy_clear_a: assert property (
        rd_stat && $past(since) > 3'h4 |-> !avs_readdata_o[STAT_BUSY_BIT])
        else $error("busy still shown after five clocks");
    irq_rise_a: assert property ($rose(irq_o) |-> since == 3'h5 || $past(mask_wr))
        else $error("interrupt rose at the wrong time");
    irq_mask_a: assert property (mask_wr && avs_writedata_i[1:0] == 2'h0 |=> !irq_o)
        else $error("masked interrupt still high");
    irq_clear_a: assert property (stat_wr && avs_writedata_i[1:0] == 2'h3
        && since != 3'h4 |=> !irq_o)
        else $error("cleared interrupt still high");
    unmapped_zero_a: assert property (done_w && avs_read_i && (avs_address_i > OFF_IRQ_MASK
        || avs_address_i[1:0] != 2'h0) |-> avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");
    read_hold_a: assert property (!($past(avs_read_i) && $past(avs_waitrequest_o))
        |-> $stable(avs_readdata_o))
        else $error("read data changed without a read");

    start_c: cover property (done_w && avs_write_i && avs_address_i == OFF_OPB_HI);
    busy_c: cover property (rd_stat && avs_readdata_o[STAT_BUSY_BIT]);
    irq_c: cover property ($rose(irq_o));
endmodule

bind mac_top mac_top_assertions #(.ADDR_W(ADDR_W)) u_checker (
    .clock_i(clock_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o));

/* tb/mac_top_test.sv */
`timescale 1ns/1ps
module mac_top_test;
    import mac_pkg::*;
    logic        clock_i;
    logic        reset_i;
    logic [5:0]  adr;
    logic        rd_en;
    logic        wr_en;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    logic        waitreq;
    logic        irq;
    int          fails;
    int          tests_run;

    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    mac_top i_mac_top (.clock_i(clock_i), .reset_i(reset_i), .avs_address_i(adr),
        .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
        .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .irq_o(irq));
    mac_cpu_model cpu (.clock_i(clock_i), .waitrequest_i(waitreq), .readdata_i(rdata),
        .address_o(adr), .read_o(rd_en), .write_o(wr_en), .writedata_o(wdata),
        .byteenable_o(be));

    task automatic finish_test();
        $display("checks run %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q, input logic [3:0] ben = 4'hF);
        bit ok;
        cpu.access(wr, a, d, ben, q, ok);
        if (!ok) begin
            fails++;
            finish_test();
        end
    endtask

    // Returns overflow, sign and the 64-bit result.
    function automatic logic [65:0] calc(input logic [31:0] a, input logic [31:0] b,
                                         input logic [63:0] acc, input mac_mode_s m);
        logic [63:0] p;
        logic [64:0] s;
        logic        sg;
        logic        ov;
        sg = m.signed_mode;
        p = {{32{sg & a[31]}}, a} * {{32{sg & b[31]}}, b};
        if (m.fixed_point) p = p << 1;
        s = {1'b0, acc} + {1'b0, p};
        ov = sg ? (acc[63] == p[63] && s[63] != acc[63]) : s[64];
        if (!m.accumulate) begin
            s = {1'b0, p};
            ov = 1'b0;
        end
        return {ov, sg & s[63], s[63:0]};
    endfunction

    initial begin
        logic [31:0] q;
        logic [31:0] a;
        logic [31:0] b;
        logic [63:0] acc;
        logic [65:0] e;
        mac_mode_s   m;
        logic [1:0]  mask;
        int          polls;
        reset_i = 1'b1;
        fails = 0;
        tests_run = 0;
        void'($urandom(32'haab5));
        repeat (8) @(posedge clock_i);
        reset_i <= 1'b0;
        bus(1'b1, 6'h34, 32'hFFFF, q);
        for (int off = 0; off < 64; off += 4) begin
            bus(1'b0, 6'(off), 32'h0, q);
            check("reset or unmapped value", 64'(q), 64'h0);
        end
        // Only the upper byte lane is enabled, so the lower byte keeps its value.
        bus(1'b1, OFF_OPA_LO, 32'h1234, q, 4'h2);
        bus(1'b0, OFF_OPA_LO, 32'h0, q);
        check("byte lane write", 64'(q), 64'h1200);
        bus(1'b1, OFF_CONTROL, 32'h7, q, 4'h2);
        bus(1'b0, OFF_CONTROL, 32'h0, q);
        check("control lane", 64'(q), 64'h0);
        acc = 64'h0;
        for (int i = 0; i < 20; i++) begin
            a = (i >= 16) ? 32'hFFFFFFFF : $urandom();
            b = (i >= 16) ? (i[0] ? 32'h80000000 : 32'hFFFFFFFF) : $urandom();
            m = mac_mode_s'(i[2:0]);
            mask = 2'(i);
            // Everything else is written before the starting word.
            bus(1'b1, OFF_IRQ_MASK, {30'h0, mask}, q);
            bus(1'b1, OFF_CONTROL, {29'h0, m}, q);
            bus(1'b1, OFF_OPA_LO, {16'h0, a[15:0]}, q);
            bus(1'b1, OFF_OPA_HI, {16'h0, a[31:16]}, q);
            bus(1'b1, OFF_OPB_LO, {16'h0, b[15:0]}, q);
            if (m.accumulate && (i >= 16 || $urandom_range(1) == 1)) begin
                acc = (i >= 16) ? {~m.signed_mode, 63'h7FFFFFFFFFFFFFFF}
                                : {$urandom(), $urandom()};
                for (int w = 0; w < 4; w++) begin
                    bus(1'b1, OFF_RESULT0 + 6'(4 * w), {16'h0, acc[16*w +: 16]}, q);
                end
            end
            e = calc(a, b, acc, m);
            bus(1'b1, OFF_OPB_HI, {16'h0, b[31:16]}, q);
            polls = 0;
            do begin
                bus(1'b0, OFF_STATUS, 32'h0, q);
                polls++;
            end while (q[STAT_BUSY_BIT] !== 1'b0 && polls < 10);
            check("busy polls", 64'(polls), 64'h3);
            check("status flags", 64'(q[2:1]), 64'({e[64], e[65]}));
            for (int w = 0; w < 4; w++) begin
                bus(1'b0, OFF_RESULT0 + 6'(4 * w), 32'h0, q);
                check("result word", 64'(q), 64'(e[16*w +: 16]));
            end
            bus(1'b0, OFF_IRQ_STAT, 32'h0, q);
            check("irq status", 64'(q), 64'({e[65], 1'b1}));
            check("irq line", 64'(irq), 64'(|({e[65], 1'b1} & mask)));
            bus(1'b1, OFF_IRQ_STAT, 32'h3, q);
            bus(1'b0, OFF_IRQ_STAT, 32'h0, q);
            check("irq cleared", 64'({q[1:0], irq}), 64'h0);
            acc = e[63:0];
        end
        finish_test();
    end
endmodule
